// file: core/bco_core.sv
// Behaviour
// - or-into-flag: carry gets carry OR bit
// - inverted or: carry gets carry OR not-bit
// - xor-into-flag: carry gets carry XOR bit
// - inverted xor: carry gets carry XOR not-bit
// - bit load copies operand bit into carry
// - inverted load copies not-bit into carry
// - bit store writes carry, other bits kept
// - inverted store writes not-carry into bit
// - bit number from three-bit immediate field
// - branch to target only when condition true
// - always variant taken, never variant never
// - higher: C|Z=0; lower-or-same: C|Z=1
// - higher-or-same: C=0; lower: C=1
// - unequal: Z=0; equal: Z=1
// - no-overflow: V=0; overflow: V=1
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module bco_core
  import bco_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output var  logic [DATA_W-1:0] o_rdata,
  output var  logic              o_carry,
  output var  logic [BYTE_W-1:0] o_operand,
  output var  logic [PC_W-1:0]   o_pc,
  output var  logic              o_taken,
  output var  logic              o_busy
);

  // ----------------------------------------------------------
  // functions
  // ----------------------------------------------------------
  function automatic logic sel_bit(
    input logic [BYTE_W-1:0]  byte_in,
    input logic [BITNO_W-1:0] bitno
  );
    sel_bit = byte_in[bitno];
  endfunction

  function automatic logic flag_carry(
    input bco_bitop_e op,
    input logic       c,
    input logic       b
  );
    logic r;
    r = c;
    case (op)
      OR_BIT_INTO_FLAG:           r = c | b;
      OR_INVERTED_BIT_INTO_FLAG:  r = c | ~b;
      XOR_BIT_INTO_FLAG:          r = c ^ b;
      XOR_INVERTED_BIT_INTO_FLAG: r = c ^ ~b;
      LOAD_BIT_TO_FLAG:           r = b;
      LOAD_INVERTED_BIT_TO_FLAG:  r = ~b;
      default:                    r = c;
    endcase
    flag_carry = r;
  endfunction

  function automatic logic cond_true(
    input bco_cond_e          cond,
    input logic [FLAGS_W-1:0] f
  );
    logic r;
    r = 1'b0;
    case (cond)
      JUMP_ALWAYS:            r = 1'b1;
      JUMP_NEVER:             r = 1'b0;
      JUMP_IF_HIGHER:         r = ~(f[FLAG_C] | f[FLAG_Z]);
      JUMP_IF_LOWER_OR_SAME:  r = f[FLAG_C] | f[FLAG_Z];
      JUMP_IF_HIGHER_OR_SAME: r = ~f[FLAG_C];
      JUMP_IF_LOWER:          r = f[FLAG_C];
      JUMP_IF_UNEQUAL:        r = ~f[FLAG_Z];
      JUMP_IF_EQUAL:          r = f[FLAG_Z];
      JUMP_IF_NO_OVERFLOW:    r = ~f[FLAG_V];
      JUMP_IF_OVERFLOW:       r = f[FLAG_V];
      default:                r = 1'b0;
    endcase
    cond_true = r;
  endfunction

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  bco_state_e         state_q;
  bco_state_e         state_d;
  logic [FLAGS_W-1:0] flags_q;
  logic [BYTE_W-1:0]  opnd_q;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    target_q;
  bco_bitcmd_s        bitcmd_q;
  bco_cond_e          cond_q;
  logic               taken_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               busy_q;

  logic               wr_flags;
  logic               wr_opnd;
  logic               wr_bitcmd;
  logic               wr_pc;
  logic               wr_target;
  logic               wr_brcmd;
  logic               idle;
  logic               do_bit;
  logic               do_branch;
  logic               is_store;
  logic               op_bit;
  logic               store_val;
  logic               new_carry;
  logic               br_true;
  logic [BYTE_W-1:0]  store_byte;

  // ----------------------------------------------------------
  // write decode
  // ----------------------------------------------------------
  always_comb begin
    wr_flags  = 1'b0;
    wr_opnd   = 1'b0;
    wr_bitcmd = 1'b0;
    wr_pc     = 1'b0;
    wr_target = 1'b0;
    wr_brcmd  = 1'b0;
    if (i_wr && i_addr == REG_FLAGS) begin
      wr_flags = 1'b1;
    end else if (i_wr && i_addr == REG_OPND) begin
      wr_opnd = 1'b1;
    end else if (i_wr && i_addr == REG_BITCMD) begin
      wr_bitcmd = 1'b1;
    end else if (i_wr && i_addr == REG_PC) begin
      wr_pc = 1'b1;
    end else if (i_wr && i_addr == REG_TARGET) begin
      wr_target = 1'b1;
    end else if (i_wr && i_addr == REG_BRCMD) begin
      wr_brcmd = 1'b1;
    end
  end

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  assign idle      = (state_q == ST_IDLE);
  assign do_bit    = (state_q == ST_BIT);
  assign do_branch = (state_q == ST_BRANCH);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_bitcmd) begin
          state_d = ST_BIT;
        end else if (wr_brcmd) begin
          state_d = ST_BRANCH;
        end
      end
      ST_BIT:    state_d = ST_IDLE;
      ST_BRANCH: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // busy flag registered so the output comes from a flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bitcmd_q <= '{op: OR_BIT_INTO_FLAG, bitno: '0};
      cond_q   <= JUMP_NEVER;
    end else if (idle && wr_bitcmd) begin
      bitcmd_q <= '{op: bco_bitop_e'(i_wdata[OP_W-1:0]),
                    bitno: i_wdata[BITNO_LSB +: BITNO_W]};
    end else if (idle && wr_brcmd) begin
      cond_q <= bco_cond_e'(i_wdata[OP_W-1:0]);
    end
  end

  // ----------------------------------------------------------
  // bit datapath
  // ----------------------------------------------------------
  assign op_bit    = sel_bit(opnd_q, bitcmd_q.bitno);
  assign new_carry = flag_carry(bitcmd_q.op, flags_q[FLAG_C], op_bit);
  assign is_store  = (bitcmd_q.op == STORE_FLAG_TO_BIT) ||
                     (bitcmd_q.op == STORE_INVERTED_FLAG_TO_BIT);
  assign store_val = (bitcmd_q.op == STORE_INVERTED_FLAG_TO_BIT) ?
                     ~flags_q[FLAG_C] : flags_q[FLAG_C];

  genvar gi;
  generate
    for (gi = 0; gi < BYTE_W; gi++) begin : g_store
      assign store_byte[gi] = (bitcmd_q.bitno == BITNO_W'(gi)) ?
                              store_val : opnd_q[gi];
    end
  endgenerate

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= FLAGS_RST;
    end else begin
      if (wr_flags) begin
        flags_q <= i_wdata[FLAGS_W-1:0];
      end
      if (do_bit && !is_store) begin
        flags_q[FLAG_C] <= new_carry;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      opnd_q <= OPND_RST;
    end else if (do_bit && is_store) begin
      opnd_q <= store_byte;
    end else if (wr_opnd) begin
      opnd_q <= i_wdata[BYTE_W-1:0];
    end
  end

  // ----------------------------------------------------------
  // branch evaluation
  // ----------------------------------------------------------
  assign br_true = cond_true(cond_q, flags_q);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_q <= PC_RST;
    end else if (do_branch) begin
      if (br_true) begin
        pc_q <= target_q;
      end else begin
        pc_q <= pc_q + BR_LEN;
      end
    end else if (wr_pc) begin
      pc_q <= i_wdata[PC_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      target_q <= PC_RST;
    end else if (wr_target) begin
      target_q <= i_wdata[PC_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      taken_q <= 1'b0;
    end else if (do_branch) begin
      taken_q <= br_true;
    end
  end

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (!i_rd) begin
      rdata_d = '0;
    end else if (i_addr == REG_FLAGS) begin
      rdata_d[FLAGS_W-1:0] = flags_q;
    end else if (i_addr == REG_OPND) begin
      rdata_d[BYTE_W-1:0] = opnd_q;
    end else if (i_addr == REG_PC) begin
      rdata_d[PC_W-1:0] = pc_q;
    end else if (i_addr == REG_TARGET) begin
      rdata_d[PC_W-1:0] = target_q;
    end else if (i_addr == REG_STATUS) begin
      rdata_d[ST_TAKEN] = taken_q;
      rdata_d[ST_BUSY]  = ~idle;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  always_comb begin
    o_rdata   = rdata_q;
    o_carry   = flags_q[FLAG_C];
    o_operand = opnd_q;
    o_pc      = pc_q;
    o_taken   = taken_q;
    o_busy    = busy_q;
  end

endmodule // bco_core
`default_nettype wire

// file: core/bco_pkg.sv
`default_nettype none
package bco_pkg;

  // ----------------------------------------------------------
  // register bus
  // ----------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PC_W   = 16;

  localparam logic [7:0] REG_FLAGS  = 8'h00;
  localparam logic [7:0] REG_OPND   = 8'h04;
  localparam logic [7:0] REG_BITCMD = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_TARGET = 8'h10;
  localparam logic [7:0] REG_BRCMD  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // ----------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAGS_W = 4;
  localparam int unsigned BITNO_W = 3;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned OP_W    = 4;
  localparam int unsigned BITNO_LSB = 4;
  localparam int unsigned ST_TAKEN  = 0;
  localparam int unsigned ST_BUSY   = 1;

  localparam logic [FLAGS_W-1:0] FLAGS_RST = 4'h0;
  localparam logic [BYTE_W-1:0]  OPND_RST  = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 16'h0000;
  localparam logic [PC_W-1:0]    BR_LEN    = 16'h0002;

  // ----------------------------------------------------------
  // operations and conditions
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    OR_BIT_INTO_FLAG           = 4'h0,
    OR_INVERTED_BIT_INTO_FLAG  = 4'h1,
    XOR_BIT_INTO_FLAG          = 4'h2,
    XOR_INVERTED_BIT_INTO_FLAG = 4'h3,
    LOAD_BIT_TO_FLAG           = 4'h4,
    LOAD_INVERTED_BIT_TO_FLAG  = 4'h5,
    STORE_FLAG_TO_BIT          = 4'h6,
    STORE_INVERTED_FLAG_TO_BIT = 4'h7
  } bco_bitop_e;

  typedef enum logic [3:0] {
    JUMP_ALWAYS            = 4'h0,
    JUMP_NEVER             = 4'h1,
    JUMP_IF_HIGHER         = 4'h2,
    JUMP_IF_LOWER_OR_SAME  = 4'h3,
    JUMP_IF_HIGHER_OR_SAME = 4'h4,
    JUMP_IF_LOWER          = 4'h5,
    JUMP_IF_UNEQUAL        = 4'h6,
    JUMP_IF_EQUAL          = 4'h7,
    JUMP_IF_NO_OVERFLOW    = 4'h8,
    JUMP_IF_OVERFLOW       = 4'h9
  } bco_cond_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_BIT    = 3'b010,
    ST_BRANCH = 3'b100
  } bco_state_e;

  typedef struct packed {
    bco_bitop_e               op;
    logic [BITNO_W-1:0]       bitno;
  } bco_bitcmd_s;

endpackage
`default_nettype wire

// file: test/bco_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bco_checker
  import bco_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              o_carry,
  input wire logic [BYTE_W-1:0] o_operand,
  input wire logic [PC_W-1:0]   o_pc,
  input wire logic              o_taken,
  input wire logic              o_busy
);
  // ----
  // shadow of commands and flags
  // ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [3:0]        op_q;
  logic [3:0]        cnd_q;
  logic [2:0]        bn_q;
  logic [1:0]        zv_q;
  logic [PC_W-1:0]   tgt_q;
  logic [BYTE_W-1:0] exp_o;
  logic [9:0]        tv;
  logic [5:0]        cv;
  logic              bit_go;
  logic              br_go;
  logic              sel;
  assign bit_go = i_wr && !o_busy && i_addr == REG_BITCMD;
  assign br_go  = i_wr && !o_busy && i_addr == REG_BRCMD;
  assign sel    = o_operand[bn_q];
  assign cv     = {!sel, sel, o_carry ^ !sel, o_carry ^ sel, o_carry | !sel, o_carry | sel};
  assign tv     = {zv_q[0], !zv_q[0], zv_q[1], !zv_q[1], o_carry, !o_carry,
                   o_carry | zv_q[1], !(o_carry | zv_q[1]), 2'b01};
  always_ff @(posedge i_core_clk) begin
    if (bit_go) op_q <= i_wdata[3:0];
    if (bit_go) bn_q <= i_wdata[6:4];
    if (br_go) cnd_q <= i_wdata[3:0];
    if (i_wr && i_addr == REG_TARGET) tgt_q <= i_wdata[PC_W-1:0];
    if (i_wr && i_addr == REG_FLAGS) zv_q <= i_wdata[2:1];
  end
  always_comb begin
    exp_o       = o_operand;
    exp_o[bn_q] = o_carry ^ op_q[0];
  end
  AST_BIT_CARRY:
    assert property (bit_go && i_wdata[3:0] < 4'h6 |=> ##1 o_carry == $past(cv[op_q]))
    else $error("carry result of bit operation wrong");
  AST_BIT_STORE:
    assert property (bit_go && i_wdata[3:1] == 3'b011 |=> ##1 o_operand == $past(exp_o) && $stable(o_carry))
    else $error("stored bit or carry wrong");
  AST_OPND_KEEP:
    assert property (bit_go && i_wdata[3:0] < 4'h6 |=> ##1 $stable(o_operand))
    else $error("carry operation changed operand");
  AST_BUSY:
    assert property (bit_go || br_go |=> o_busy ##1 !o_busy)
    else $error("busy pulse wrong");
  AST_BR_PC:
    assert property (br_go |=> ##1 o_taken == $past(cnd_q < 4'hA && tv[cnd_q])
      && o_pc == ($past(cnd_q < 4'hA && tv[cnd_q]) ? $past(tgt_q) : $past(o_pc) + BR_LEN))
    else $error("branch outcome wrong");
  AST_BR_FLAGS:
    assert property (br_go |=> ##1 $stable(o_carry))
    else $error("branch changed carry");
  AST_ALWAYS:
    assert property (br_go && i_wdata[3:0] == 4'h0 |=> ##1 o_taken && o_pc == $past(tgt_q))
    else $error("always branch not taken");
  AST_NEVER:
    assert property (br_go && i_wdata[3:0] == 4'h1 |=> ##1 !o_taken && o_pc == $past(o_pc) + BR_LEN)
    else $error("never branch taken");
  cover property (bit_go);
  cover property (br_go ##2 o_taken);
  cover property (br_go ##2 !o_taken);
endmodule // bco_checker
bind bco_core bco_checker bco_checker_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .o_carry, .o_operand, .o_pc, .o_taken, .o_busy);
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top
  import bco_pkg::*;
;
  logic              i_core_clk;
  logic              i_rst;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic              o_carry;
  logic [BYTE_W-1:0] o_operand;
  logic [PC_W-1:0]   o_pc;
  logic              o_taken;
  logic              o_busy;
  int                errors;
  int                n_compared;
  logic              c;
  logic              b;
  logic              ec;
  logic              t;
  logic [2:0]        bn;
  logic [7:0]        ob;
  logic [PC_W-1:0]   p;
  bco_core bco_core_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_carry, .o_operand, .o_pc, .o_taken, .o_busy);
  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit g = 1);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    if (g) begin
      i_wr <= 1'b0;
      @(posedge i_core_clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(n, e, o_rdata)
    @(posedge i_core_clk);
  endtask
  function automatic logic tk(input int k, input logic [3:0] f);
    logic [9:0] v;
    v = {f[1], !f[1], f[2], !f[2], f[0], !f[0], f[0] | f[2], !(f[0] | f[2]), 2'b01};
    return (k < 10) ? v[k] : 1'b0;
  endfunction
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    #1000000;
    errors++;
    summarize();
  end
  initial begin
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    rd(REG_FLAGS, 32'h0, "flags rst");
    rd(REG_OPND, 32'h0, "opnd rst");
    rd(REG_PC, 32'h0, "pc rst");
    rd(REG_TARGET, 32'h0, "target rst");
    rd(REG_STATUS, 32'h0, "status rst");
    rd(8'h1C, 32'h0, "unmapped");
    rd(REG_BITCMD, 32'h0, "write only");
    wr(REG_STATUS, 32'h3);
    rd(REG_STATUS, 32'h0, "status ro");
    wr(REG_FLAGS, 32'hFFFFFFFF);
    rd(REG_FLAGS, 32'h0000000F, "flags rw");
    $display("test registers done");
    for (int op = 0; op < 6; op++) begin
      for (int k = 0; k < 4; k++) begin
        bn = 3'((op * 4 + k) % 8);
        c = k[0];
        b = k[1];
        ob = b ? (8'h01 << bn) : ~(8'h01 << bn);
        ec = (op == 0) ? c | b : (op == 1) ? c | !b : (op == 2) ? c ^ b : (op == 3) ? c ^ !b : (op == 4) ? b : !b;
        wr(REG_FLAGS, {28'h0, 3'b101, c});
        wr(REG_OPND, {24'h0, ob});
        wr(REG_BITCMD, {25'h0, bn, 4'(op)});
        rd(REG_FLAGS, {28'h0, 3'b101, ec}, "flags carry op");
        `CHK("carry", ec, o_carry)
        `CHK("operand kept", ob, o_operand)
      end
    end
    wr(REG_FLAGS, 32'hA);
    wr(REG_OPND, 32'h01);
    wr(REG_BITCMD, {25'h0, 3'h0, LOAD_BIT_TO_FLAG}, 0);
    fork
      #1 `CHK("busy", 1'b1, o_busy)
    join_none
    wr(REG_BITCMD, {25'h0, 3'h0, LOAD_INVERTED_BIT_TO_FLAG});
    rd(REG_FLAGS, 32'hB, "busy refusal");
    wr(REG_BITCMD, {25'h0, 3'h0, 4'h8});
    rd(REG_FLAGS, 32'hB, "unused op flags");
    `CHK("unused op operand", 8'h01, o_operand)
    $display("test carry ops done");
    for (int op = 6; op < 8; op++) begin
      for (int k = 0; k < 4; k++) begin
        bn = 3'(k * 2 + op - 6);
        c = k[0];
        ob = k[1] ? 8'hFF : 8'h00;
        wr(REG_FLAGS, {28'h0, 3'b101, c});
        wr(REG_OPND, {24'h0, ob});
        wr(REG_BITCMD, {25'h0, bn, 4'(op)});
        ob[bn] = c ^ (op == 7);
        rd(REG_OPND, {24'h0, ob}, "stored bit");
        rd(REG_FLAGS, {28'h0, 3'b101, c}, "flags kept");
      end
    end
    $display("test store ops done");
    for (int k = 0; k < 16; k++) begin
      for (int f = 0; f < 8; f++) begin
        p = 16'(4096 + k * 16 + f);
        t = tk(k, 4'(f));
        wr(REG_PC, {16'h0, p});
        wr(REG_TARGET, {16'h0, ~p});
        wr(REG_FLAGS, {28'h0, 4'(f)});
        wr(REG_BRCMD, 32'(k));
        rd(REG_STATUS, {31'h0, t}, "status taken");
        `CHK("pc", t ? ~p : p + BR_LEN, o_pc)
        `CHK("taken", t, o_taken)
        rd(REG_FLAGS, {28'h0, 4'(f)}, "flags branch");
      end
    end
    $display("test branches done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
